// ===== hw/sta_core.sv
// Functional notes
// - Interchange command swaps lower and upper memory halves channel by channel.
// - In a proper pass the upper half is the donor and the lower half the acceptor.
// - Donor scaled by decimal factor, fraction discarded before combining.
// - Proper cycle needs readout display mode, full 512 channels, decade lines on.
// - Start with decade lines off is refused; no cycle begins.
// - Result for each channel is presented on the display port when done.
// - Add selector adds scaled donor; subtract selector subtracts it.
// - Channel zero is not combined in a proper pass; it receives a meaningless value.
// - Start in half-size mode runs a slow improper pass that mangles data.
// - Repeating with opposite arithmetic restores data, except channel zero after a proper pass; modular counts make this exact.
// - Donor and acceptor are 256 points each in a proper pass, combined pairwise.
`default_nettype none

module sta_core (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [sta_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic start_button_pin,
  output logic display_strobe,
  output logic [sta_pkg::IDX_W-1:0] display_channel,
  output logic [sta_pkg::COUNT_W-1:0] display_count,
  output logic busy
);
  import sta_pkg::*;

  typedef struct packed {
    sta_state_t state;
    logic [IDX_W-1:0] idx;
    logic [15:0] wait_cnt;
    logic crt;
    logic full;
    logic decade;
    logic subtract;
    logic [1:0] mult;
    logic forced_stop;
    logic refused;
    logic [9:0] done_cnt;
    logic ack;
    logic [31:0] dat;
    logic disp_stb;
    logic [IDX_W-1:0] disp_ch;
    logic [COUNT_W-1:0] disp_cnt;
    logic [CHANNELS-1:0][COUNT_W-1:0] mem;
  } sta_regs_t;

  sta_regs_t r_reg, r_next;

  logic button_rise;

  sta_pin_sync u_button (
    .clock(clock),
    .reset_n(reset_n),
    .pin(start_button_pin),
    .level(),
    .rise(button_rise)
  );

  // Integer part of donor times decimal factor
  function automatic logic [COUNT_W-1:0] scale(input logic [COUNT_W-1:0] val,
                                               input logic [1:0] sel);
    logic [COUNT_W-1:0] div;
    div = DIV_X1;
    case (sel)
      2'h0: div = DIV_X1;
      2'h1: div = DIV_X0_1;
      2'h2: div = DIV_X0_01;
      default: div = DIV_X0_001;
    endcase
    return val / div;
  endfunction

  // Wrapping arithmetic keeps add and subtract exact inverses
  function automatic logic [COUNT_W-1:0] combine(input logic [COUNT_W-1:0] acc,
                                                 input logic [COUNT_W-1:0] don,
                                                 input logic sub);
    logic [COUNT_W-1:0] res;
    res = sub ? acc - don : acc + don;
    return res;
  endfunction

  // Byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  always_comb begin
    logic req;
    logic start_trig;
    logic swap_trig;
    logic [31:0] ctrl_word;
    logic [31:0] wr_word;
    logic [IDX_W-1:0] mem_idx;
    logic [COUNT_W-1:0] don;
    logic [COUNT_W-1:0] res;
    req = 1'b0;
    start_trig = 1'b0;
    swap_trig = 1'b0;
    ctrl_word = '0;
    wr_word = '0;
    mem_idx = '0;
    don = '0;
    res = '0;
    r_next = r_reg;
    r_next.ack = 1'b0;
    r_next.disp_stb = 1'b0;

    ctrl_word[CTRL_CRT_BIT] = r_reg.crt;
    ctrl_word[CTRL_FULL_BIT] = r_reg.full;
    ctrl_word[CTRL_DECADE_BIT] = r_reg.decade;
    ctrl_word[CTRL_SUB_BIT] = r_reg.subtract;
    ctrl_word[CTRL_MULT_LSB +: 2] = r_reg.mult;
    ctrl_word[CTRL_STOP_BIT] = r_reg.forced_stop;
    mem_idx = wb_adr_i[ADR_MEM_BIT-1:2];

    // Bus slave: one wait state, ack dropped after one cycle
    req = wb_cyc_i && wb_stb_i && !r_reg.ack;
    if (req) begin
      r_next.ack = 1'b1;
      r_next.dat = '0;
      if (wb_we_i) begin
        if (wb_adr_i[ADR_MEM_BIT]) begin
          // Channel writes land only while no pass is running
          if (r_reg.state == STA_IDLE) begin
            wr_word = merge({8'h00, r_reg.mem[mem_idx]}, wb_dat_i, wb_sel_i);
            r_next.mem[mem_idx] = wr_word[COUNT_W-1:0];
          end
        end else if (wb_adr_i == ADR_CTRL) begin
          wr_word = merge(ctrl_word, wb_dat_i, wb_sel_i);
          r_next.crt = wr_word[CTRL_CRT_BIT];
          r_next.full = wr_word[CTRL_FULL_BIT];
          r_next.decade = wr_word[CTRL_DECADE_BIT];
          r_next.subtract = wr_word[CTRL_SUB_BIT];
          r_next.mult = wr_word[CTRL_MULT_LSB +: 2];
          r_next.forced_stop = wr_word[CTRL_STOP_BIT];
        end else if (wb_adr_i == ADR_CMD) begin
          if (wb_sel_i[0]) begin
            start_trig = wb_dat_i[CMD_START_BIT];
            swap_trig = wb_dat_i[CMD_SWAP_BIT];
          end
        end
      end else begin
        if (wb_adr_i[ADR_MEM_BIT]) begin
          r_next.dat = {8'h00, r_reg.mem[mem_idx]};
        end else if (wb_adr_i == ADR_CTRL) begin
          r_next.dat = ctrl_word;
        end else if (wb_adr_i == ADR_STATUS) begin
          r_next.dat[STAT_BUSY_BIT] = (r_reg.state != STA_IDLE);
          r_next.dat[STAT_SWAP_BIT] = (r_reg.state == STA_SWAP);
          r_next.dat[STAT_REFUSED_BIT] = r_reg.refused;
          r_next.dat[STAT_DONE_LSB +: 10] = r_reg.done_cnt;
        end
      end
    end

    start_trig = start_trig || button_rise;

    case (r_reg.state)
      STA_IDLE: begin
        if (swap_trig) begin
          // Interchange while running would corrupt a pass, so it is taken only in idle and dropped otherwise
          r_next.state = STA_SWAP;
          r_next.idx = '0;
        end else if (start_trig && !r_reg.forced_stop) begin
          if (!r_reg.decade || !r_reg.crt) begin
            r_next.refused = 1'b1;
          end else if (r_reg.full) begin
            r_next.state = STA_PROPER;
            r_next.refused = 1'b0;
            r_next.idx = '0;
            r_next.done_cnt = '0;
          end else begin
            r_next.state = STA_IMPROPER;
            r_next.refused = 1'b0;
            r_next.idx = '0;
            r_next.done_cnt = '0;
            r_next.wait_cnt = SLOW_STEP_LOAD;
          end
        end
      end
      STA_PROPER: begin
        // One acceptor channel per clock, donor is index plus half
        don = scale(r_reg.mem[r_reg.idx + HALF_OFFSET], r_reg.mult);
        if (r_reg.idx == '0) begin
          res = don;
        end else begin
          res = combine(r_reg.mem[r_reg.idx], don, r_reg.subtract);
        end
        r_next.mem[r_reg.idx] = res;
        r_next.disp_stb = 1'b1;
        r_next.disp_ch = r_reg.idx;
        r_next.disp_cnt = res;
        r_next.done_cnt = r_reg.done_cnt + 10'h001;
        if (r_reg.idx == LAST_PROPER_IDX) begin
          r_next.state = STA_IDLE;
        end else begin
          r_next.idx = r_reg.idx + 9'h001;
        end
      end
      STA_IMPROPER: begin
        // Slow pass pairs the wrong quarters; the opposite arithmetic undoes it
        if (r_reg.wait_cnt != '0) begin
          r_next.wait_cnt = r_reg.wait_cnt - 16'h0001;
        end else begin
          don = scale(r_reg.mem[r_reg.idx + IMPROPER_OFFSET], r_reg.mult);
          res = combine(r_reg.mem[r_reg.idx], don, r_reg.subtract);
          r_next.mem[r_reg.idx] = res;
          r_next.disp_stb = 1'b1;
          r_next.disp_ch = r_reg.idx;
          r_next.disp_cnt = res;
          r_next.done_cnt = r_reg.done_cnt + 10'h001;
          r_next.wait_cnt = SLOW_STEP_LOAD;
          if (r_reg.idx == LAST_IMPROPER_IDX) begin
            r_next.state = STA_IDLE;
          end else begin
            r_next.idx = r_reg.idx + 9'h001;
          end
        end
      end
      STA_SWAP: begin
        r_next.mem[r_reg.idx] = r_reg.mem[r_reg.idx + HALF_OFFSET];
        r_next.mem[r_reg.idx + HALF_OFFSET] = r_reg.mem[r_reg.idx];
        if (r_reg.idx == LAST_PROPER_IDX) begin
          r_next.state = STA_IDLE;
        end else begin
          r_next.idx = r_reg.idx + 9'h001;
        end
      end
      default: begin
        r_next.state = STA_IDLE;
      end
    endcase

    // Forced stop holds the control circuits off, aborting a proper or improper pass; an interchange runs on
    if (r_next.forced_stop && r_next.state != STA_SWAP) begin
      r_next.state = STA_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      r_reg <= '0;
      r_reg.state <= STA_IDLE;
      r_reg.crt <= CTRL_RESET[CTRL_CRT_BIT];
      r_reg.full <= CTRL_RESET[CTRL_FULL_BIT];
      r_reg.decade <= CTRL_RESET[CTRL_DECADE_BIT];
      r_reg.subtract <= CTRL_RESET[CTRL_SUB_BIT];
      r_reg.mult <= CTRL_RESET[CTRL_MULT_LSB +: 2];
      r_reg.forced_stop <= CTRL_RESET[CTRL_STOP_BIT];
    end else begin
      r_reg <= r_next;
    end
  end

  assign wb_ack_o = r_reg.ack;
  assign wb_dat_o = r_reg.dat;
  assign display_strobe = r_reg.disp_stb;
  assign display_channel = r_reg.disp_ch;
  assign display_count = r_reg.disp_cnt;
  assign busy = (r_reg.state != STA_IDLE);
endmodule // sta_core

`default_nettype wire

// ===== hw/sta_pin_sync.sv
`default_nettype none

module sta_pin_sync (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic pin,
  output logic level,
  output logic rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
  } sta_sync_t;

  sta_sync_t r_reg, r_next;

  // First stage only feeds the second; the level follows once stages two and three agree
  always_comb begin
    r_next = r_reg;
    r_next.s1 = pin;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    r_next.rise = 1'b0;
    if (r_reg.s2 == r_reg.s3 && r_reg.s3 != r_reg.level) begin
      r_next.level = r_reg.s3;
      r_next.rise = r_reg.s3;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign level = r_reg.level;
  assign rise = r_reg.rise;
endmodule // sta_pin_sync

`default_nettype wire

// ===== inc/sta_pkg.sv
`default_nettype none

package sta_pkg;

  // Memory geometry
  localparam int CHANNELS = 512;
  localparam int HALF = 256;
  localparam int COUNT_W = 24;
  localparam int IDX_W = 9;
  localparam int ADR_W = 12;
  localparam logic [IDX_W-1:0] HALF_OFFSET = 9'h100;
  localparam logic [IDX_W-1:0] LAST_PROPER_IDX = 9'h0FF;
  // Half-size pass only reaches the lower quarter pair
  localparam logic [IDX_W-1:0] IMPROPER_OFFSET = 9'h080;
  localparam logic [IDX_W-1:0] LAST_IMPROPER_IDX = 9'h07F;

  // Register byte offsets
  localparam logic [ADR_W-1:0] ADR_CTRL = 12'h000;
  localparam logic [ADR_W-1:0] ADR_CMD = 12'h004;
  localparam logic [ADR_W-1:0] ADR_STATUS = 12'h008;
  localparam int ADR_MEM_BIT = 11;

  // Control register fields
  localparam int CTRL_CRT_BIT = 0;
  localparam int CTRL_FULL_BIT = 1;
  localparam int CTRL_DECADE_BIT = 2;
  localparam int CTRL_SUB_BIT = 3;
  localparam int CTRL_MULT_LSB = 4;
  localparam int CTRL_STOP_BIT = 6;
  localparam logic [7:0] CTRL_RESET = 8'h40;

  // Command register fields
  localparam int CMD_START_BIT = 0;
  localparam int CMD_SWAP_BIT = 1;

  // Status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SWAP_BIT = 1;
  localparam int STAT_REFUSED_BIT = 2;
  localparam int STAT_DONE_LSB = 8;

  // Decimal multiplier selection: x1, x.1, x.01, x.001
  localparam logic [COUNT_W-1:0] DIV_X1 = 24'h000001;
  localparam logic [COUNT_W-1:0] DIV_X0_1 = 24'h00000A;
  localparam logic [COUNT_W-1:0] DIV_X0_01 = 24'h000064;
  localparam logic [COUNT_W-1:0] DIV_X0_001 = 24'h0003E8;

  // Timing
  localparam int CLOCK_NS = 100;
  localparam int SLOW_STEP_NS = 100000;
  localparam int SLOW_STEP_CYCLES = (SLOW_STEP_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam logic [15:0] SLOW_STEP_LOAD = 16'(SLOW_STEP_CYCLES - 1);

  typedef enum logic [1:0] {
    STA_IDLE = 2'b00,
    STA_PROPER = 2'b01,
    STA_IMPROPER = 2'b10,
    STA_SWAP = 2'b11
  } sta_state_t;

endpackage

`default_nettype wire

// ===== testbench/sta_core_monitor.sv
`default_nettype none

module sta_core_monitor (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic display_strobe,
  input wire logic [sta_pkg::IDX_W-1:0] display_channel,
  input wire logic [sta_pkg::COUNT_W-1:0] display_count,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  import sta_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  a_strobe_step: assert property (
    display_strobe ##1 display_strobe |-> display_channel == $past(display_channel) + 9'h001)
    else $error("channel did not step by one");
  a_first_chan: assert property (
    $rose(busy) ##1 display_strobe |-> display_channel == 9'h000)
    else $error("pass did not begin at channel 0");
  a_strobe_busy: assert property (display_strobe |-> $past(busy))
    else $error("strobe outside a pass");
  a_idle_quiet: assert property (!$past(busy) && !busy |-> !display_strobe)
    else $error("strobe while idle");
  a_chan_hold: assert property (!display_strobe |-> $stable(display_channel))
    else $error("channel moved without strobe");
  a_count_hold: assert property (!display_strobe |-> $stable(display_count))
    else $error("count moved without strobe");
  c_last: cover property (display_strobe && display_channel == 9'h0FF);
  c_done: cover property ($fell(busy));
  c_write: cover property (wb_ack_o && wb_we_i);
endmodule // sta_core_monitor

bind sta_core sta_core_monitor u_mon (.clock, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_ack_o, .display_strobe, .display_channel, .display_count, .busy);

`default_nettype wire

// ===== testbench/sta_operator.sv
`default_nettype none

module sta_operator (
  input wire logic clock,
  input wire logic busy,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pin = 1'b0;
  // Held until the pass is seen; a short tap could be lost in the sync
  task automatic press();
    @(posedge clock);
    pin <= 1'b1;
    do @(posedge clock); while (busy !== 1'b1);
    pin <= 1'b0;
  endtask
endmodule // sta_operator

`default_nettype wire

// ===== testbench/tb.sv
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sta_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADR_W-1:0] adr = 12'h000;
  logic [31:0] dat = 32'h00000000;
  logic [31:0] rd;
  logic [31:0] dat_o;
  logic ack, strobe, busy, pin;
  logic [IDX_W-1:0] chan;
  logic [COUNT_W-1:0] cnt;
  logic [COUNT_W-1:0] seen5;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_strobe = 0;
  always #50 clock = ~clock;
  sta_core u_dut (.clock(clock), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .start_button_pin(pin), .display_strobe(strobe),
    .display_channel(chan), .display_count(cnt), .busy(busy));
  sta_operator u_op (.clock(clock), .busy(busy), .pin(pin));
  always @(posedge clock) if (strobe === 1'b1) begin
    n_strobe <= n_strobe + 1;
    if (chan === 9'h005) seen5 <= cnt;
  end
  function automatic logic [11:0] ch(input int i);
    return 12'h800 + 12'(i * 4);
  endfunction
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clock); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g, input string what);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string what);
    bus(1'b0, a, 32'h00000000);
    chk(e, rd, what);
  endtask
  task automatic wait_idle();
    @(posedge clock);
    while (busy !== 1'b0) @(posedge clock);
    // Last strobe is counted on the edge that shows busy low
    @(posedge clock);
  endtask
  task automatic run(input logic [31:0] c);
    bus(1'b1, ADR_CTRL, c);
    bus(1'b1, ADR_CMD, 32'h00000001);
    wait_idle();
  endtask
  task automatic t_reset();
    rchk(ADR_CTRL, 32'h00000040, "ctrl");
    rchk(ADR_STATUS, 32'h00000000, "status");
    rchk(12'h00C, 32'h00000000, "unmapped");
    $display("t_reset done");
  endtask
  task automatic t_add();
    bus(1'b1, ch(5), 32'h0000000A);
    bus(1'b1, ch(261), 32'h00000167);
    bus(1'b1, ch(0), 32'h00000007);
    bus(1'b1, ch(256), 32'h000001F4);
    run(32'h00000027);
    chk(32'd256, 32'(n_strobe), "strobes");
    chk(32'h0000000D, 32'(seen5), "shown");
    rchk(ch(5), 32'h0000000D, "ch5");
    rchk(ch(261), 32'h00000167, "ch261");
    rchk(ch(0), 32'h00000005, "ch0");
    $display("t_add done");
  endtask
  task automatic t_scale();
    run(32'h00000037);
    rchk(ch(5), 32'h0000000D, "ch5");
    $display("t_scale done");
  endtask
  task automatic t_button();
    bus(1'b1, ADR_CTRL, 32'h0000002F);
    u_op.press();
    wait_idle();
    rchk(ch(5), 32'h0000000A, "ch5");
    $display("t_button done");
  endtask
  task automatic t_refuse();
    int base;
    base = n_strobe;
    run(32'h00000023);
    chk(32'h00000000, 32'(busy), "busy");
    chk(32'(base), 32'(n_strobe), "strobes");
    bus(1'b0, ADR_STATUS, 32'h00000000);
    chk(32'h00000004, rd & 32'h00000007, "refused");
    run(32'h00000026);
    chk(32'(base), 32'(n_strobe), "crt off strobes");
    $display("t_refuse done");
  endtask
  task automatic t_swap();
    bus(1'b1, ADR_CTRL, 32'h00000040);
    bus(1'b1, ADR_CMD, 32'h00000002);
    wait_idle();
    rchk(ch(5), 32'h00000167, "ch5");
    rchk(ch(261), 32'h0000000A, "ch261");
    $display("t_swap done");
  endtask
  task automatic t_half();
    int base;
    base = n_strobe;
    bus(1'b1, ADR_CTRL, 32'h00000025);
    bus(1'b1, ADR_CMD, 32'h00000001);
    repeat (900) @(posedge clock);
    chk(32'h00000001, 32'(busy), "busy");
    chk(32'(base), 32'(n_strobe), "strobes");
    bus(1'b1, ADR_CTRL, 32'h00000065);
    wait_idle();
    $display("t_half done");
  endtask
  task automatic end_of_test();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Whole run is a few thousand cycles; this only catches a hang
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    t_reset();
    t_add();
    t_scale();
    t_button();
    t_refuse();
    t_swap();
    t_half();
    end_of_test();
  end
endmodule // tb

`default_nettype wire
